// [logic/cpudec_regs.svh]
/*
  named opcodes, opcode fields and flag positions of the instruction decoder.
  assumes inclusion by the decoder module only.
*/
`ifndef CPUDEC_REGS_SVH
`define CPUDEC_REGS_SVH

// ==========================================================
// opcode fields
`define CPUDEC_ROW_HI 7
`define CPUDEC_ROW_LO 4
`define CPUDEC_COL_HI 3
`define CPUDEC_COL_LO 0
`define CPUDEC_BIT_HI 6
`define CPUDEC_BIT_LO 4
`define CPUDEC_SETSEL 7

// ==========================================================
// flag positions in the status byte
`define CPUDEC_FLAG_C 0
`define CPUDEC_FLAG_Z 1
`define CPUDEC_FLAG_V 6
`define CPUDEC_FLAG_N 7

// ==========================================================
// named opcodes
`define CPUDEC_OP_BREAK 8'h00
`define CPUDEC_OP_NOP 8'hea
`define CPUDEC_OP_WAIT 8'hcb
`define CPUDEC_OP_STOP 8'hdb
`define CPUDEC_OP_BPL 8'h10
`define CPUDEC_OP_BMI 8'h30
`define CPUDEC_OP_BVC 8'h50
`define CPUDEC_OP_BVS 8'h70
`define CPUDEC_OP_BRA 8'h80
`define CPUDEC_OP_BCC 8'h90
`define CPUDEC_OP_BCS 8'hb0
`define CPUDEC_OP_BNE 8'hd0
`define CPUDEC_OP_BEQ 8'hf0
`define CPUDEC_OP_TXS 8'h9a
`define CPUDEC_OP_PHX 8'hda
`define CPUDEC_OP_PHY 8'h5a
`define CPUDEC_OP_PLX 8'hfa
`define CPUDEC_OP_PLY 8'h7a
`define CPUDEC_OP_PHA 8'h48
`define CPUDEC_OP_PHP 8'h08
`define CPUDEC_OP_PLA 8'h68
`define CPUDEC_OP_PLP 8'h28
`define CPUDEC_OP_ASLA 8'h0a
`define CPUDEC_OP_ROLA 8'h2a
`define CPUDEC_OP_LSRA 8'h4a
`define CPUDEC_OP_RORA 8'h6a

// ==========================================================
// matrix columns and rows, and the test-set, test-reset and store-zero opcodes
`define CPUDEC_COL_BITMEM 4'h7
`define CPUDEC_COL_BITBR 4'hf
`define CPUDEC_COL_ALU1 4'h1
`define CPUDEC_COL_ALU2 4'h2
`define CPUDEC_COL_ALU5 4'h5
`define CPUDEC_COL_ALU9 4'h9
`define CPUDEC_COL_ALUD 4'hd
`define CPUDEC_COL_SH6 4'h6
`define CPUDEC_COL_SHE 4'he
`define CPUDEC_ROW_ADC 3'h3
`define CPUDEC_ROW_SBC 3'h7
`define CPUDEC_ROW_CMP 3'h6
`define CPUDEC_ROW_ASL 3'h0
`define CPUDEC_ROW_ROL 3'h1
`define CPUDEC_ROW_LSR 3'h2
`define CPUDEC_ROW_ROR 3'h3
`define CPUDEC_COL_CPI0 4'h0
`define CPUDEC_COL_CPI4 4'h4
`define CPUDEC_COL_CPIC 4'hc
`define CPUDEC_ROW_CPY 4'hc
`define CPUDEC_ROW_CPX 4'he
`define CPUDEC_OP_TSB_ZP 8'h04
`define CPUDEC_OP_TSB_A 8'h0c
`define CPUDEC_OP_TRB_ZP 8'h14
`define CPUDEC_OP_TRB_A 8'h1c
`define CPUDEC_OP_STZ_ZP 8'h64
`define CPUDEC_OP_STZ_ZX 8'h74
`define CPUDEC_OP_STZ_A 8'h9c
`define CPUDEC_OP_STZ_AX 8'h9e

`endif

// [logic/cpudec_pkg.sv]
/*
  types of the instruction decoder.
  assumes the constants header sits beside it.
*/
package cpudec_pkg;

    // ======================================================
    // operations
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_ADD_CARRY = 5'h01,
        OP_SUBTRACT_BORROW = 5'h02,
        OP_SHIFT_LEFT = 5'h03,
        OP_SHIFT_RIGHT = 5'h04,
        OP_ROTATE_LEFT = 5'h05,
        OP_ROTATE_RIGHT = 5'h06,
        OP_COMPARE = 5'h07,
        OP_PUSH = 5'h08,
        OP_PULL = 5'h09,
        OP_TEST_SET = 5'h0a,
        OP_TEST_RESET = 5'h0b,
        OP_STORE_ZERO = 5'h0c,
        OP_TRANSFER = 5'h0d,
        OP_BRANCH = 5'h0e,
        OP_BIT_SET = 5'h0f,
        OP_BIT_RESET = 5'h10,
        OP_BRANCH_BIT = 5'h11,
        OP_BREAK = 5'h12,
        OP_WAIT = 5'h13,
        OP_STOP = 5'h14,
        OP_OTHER = 5'h15
    } cpudec_op_t;

    // register selects for source and destination
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_ACC = 3'h1,
        SEL_X = 3'h2,
        SEL_Y = 3'h3,
        SEL_STATUS = 3'h4,
        SEL_STACK = 3'h5,
        SEL_MEMORY = 3'h6
    } cpudec_sel_t;

    // decoded instruction
    typedef struct packed {
        cpudec_op_t op;
        cpudec_sel_t src;
        cpudec_sel_t dst;
        logic branch_taken;
        logic [2:0] bit_index;
        logic bit_value;
        logic use_carry;
        logic carry_inverted;
        logic write_result;
        logic update_flags;
    } cpudec_ctl_t;

    // state of the decoder
    typedef struct packed {
        cpudec_ctl_t ctl;
        logic valid;
    } cpudec_state_t;

endpackage

// [logic/cpudec_decoder.sv]
/*
  instruction decoder: turns a fetched opcode and the status flags into
  control for the execution datapath, registered one cycle later.
  assumes opcode and flags come from logic on mclk_i; no synchroniser.
*/
`include "cpudec_regs.svh"

// Functional notes
// [RL1] branch_carry_clear taken only when carry_flag is 0
// [RL2] branch_carry_set taken only when carry_flag is 1
// [RL3] branch_zero_set taken only when zero_flag is 1
// [RL4] branch_zero_clear taken only when zero_flag is 0
// [RL5] branch_negative_set taken only when negative_flag is 1
// [RL6] branch_negative_clear taken only when negative_flag is 0
// [RL7] branch_overflow_clear taken only when overflow_flag is 0
// [RL8] branch_overflow_set taken only when overflow_flag is 1
// [RL9] add with carry: accumulator plus operand plus carry into accumulator
// [RL10] subtract_with_borrow: accumulator minus operand, carry is inverted borrow
// [RL11] shift_left_arith shifts accumulator or memory left, writes back in place
// [RL12] shift_right_logical shifts accumulator or memory right, writes back in place
// [RL13] rotate_left_carry rotates left through carry, accumulator or memory
// [RL14] rotate_right_carry rotates right through carry, accumulator or memory
// [RL15] compare_accumulator sets flags, accumulator unchanged
// [RL16] compare_index_x and compare_index_y set flags, indexes unchanged
// [RL17] push and pull of X and Y besides accumulator and status
// [RL18] test_set_bits tests operand, writes operand with accumulator ones set
// [RL19] test_reset_bits tests operand, writes operand with accumulator ones cleared
// [RL20] store_zero writes a zero byte to memory
// [RL21] x_to_stack_pointer copies X into the stack pointer
// [RL22] high nibble is row, low nibble column; break, nop, wait, stop placed
// [RL23] bit opcodes take bit index from bits 6..4, bit 7 picks set
// [RL24] branch_always always taken; unassigned opcodes change no register
module cpudec_decoder
    import cpudec_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // fetch side
    input wire logic opcode_valid_i,
    input wire logic [7:0] opcode_i,
    // status flags
    input wire logic [7:0] status_i,
    // datapath side
    output logic ctl_valid_o,
    output cpudec_ctl_t ctl_o
);

    // ======================================================
    // helpers
    function automatic cpudec_ctl_t ctl_blank();
        cpudec_ctl_t c;
        c = '0;
        c.op = OP_NONE;
        c.src = SEL_NONE;
        c.dst = SEL_NONE;
        return c;
    endfunction

    function automatic logic is_alu_col(input logic [3:0] col);
        return (col == `CPUDEC_COL_ALU1) || (col == `CPUDEC_COL_ALU2) ||
               (col == `CPUDEC_COL_ALU5) || (col == `CPUDEC_COL_ALU9) ||
               (col == `CPUDEC_COL_ALUD);
    endfunction

    // ======================================================
    // combinational decode
    cpudec_state_t s_q;
    cpudec_state_t s_d;
    logic [3:0] row;
    logic [3:0] col;
    logic fc;
    logic fz;
    logic fn;
    logic fv;
    logic acc_form;

    always_comb begin
        row = opcode_i[`CPUDEC_ROW_HI:`CPUDEC_ROW_LO]; // [RL22]
        col = opcode_i[`CPUDEC_COL_HI:`CPUDEC_COL_LO]; // [RL22]
        fc = status_i[`CPUDEC_FLAG_C];
        fz = status_i[`CPUDEC_FLAG_Z];
        fn = status_i[`CPUDEC_FLAG_N];
        fv = status_i[`CPUDEC_FLAG_V];
        acc_form = (opcode_i == `CPUDEC_OP_ASLA) || (opcode_i == `CPUDEC_OP_ROLA) ||
                   (opcode_i == `CPUDEC_OP_LSRA) || (opcode_i == `CPUDEC_OP_RORA);
        s_d.valid = opcode_valid_i;
        s_d.ctl = ctl_blank(); // [RL24]
        case (opcode_i)
            `CPUDEC_OP_BCC: begin
                s_d.ctl.op = OP_BRANCH;
                s_d.ctl.branch_taken = !fc; // [RL1]
            end
            `CPUDEC_OP_BCS: begin
                s_d.ctl.op = OP_BRANCH;
                s_d.ctl.branch_taken = fc; // [RL2]
            end
            `CPUDEC_OP_BEQ: begin
                s_d.ctl.op = OP_BRANCH;
                s_d.ctl.branch_taken = fz; // [RL3]
            end
            `CPUDEC_OP_BNE: begin
                s_d.ctl.op = OP_BRANCH;
                s_d.ctl.branch_taken = !fz; // [RL4]
            end
            `CPUDEC_OP_BMI: begin
                s_d.ctl.op = OP_BRANCH;
                s_d.ctl.branch_taken = fn; // [RL5]
            end
            `CPUDEC_OP_BPL: begin
                s_d.ctl.op = OP_BRANCH;
                s_d.ctl.branch_taken = !fn; // [RL6]
            end
            `CPUDEC_OP_BVC: begin
                s_d.ctl.op = OP_BRANCH;
                s_d.ctl.branch_taken = !fv; // [RL7]
            end
            `CPUDEC_OP_BVS: begin
                s_d.ctl.op = OP_BRANCH;
                s_d.ctl.branch_taken = fv; // [RL8]
            end
            `CPUDEC_OP_BRA: begin
                s_d.ctl.op = OP_BRANCH;
                s_d.ctl.branch_taken = 1'b1; // [RL24]
            end
            `CPUDEC_OP_BREAK: s_d.ctl.op = OP_BREAK; // [RL22]
            `CPUDEC_OP_WAIT: s_d.ctl.op = OP_WAIT; // [RL22]
            `CPUDEC_OP_STOP: s_d.ctl.op = OP_STOP; // [RL22]
            `CPUDEC_OP_NOP: s_d.ctl.op = OP_NONE; // [RL22]
            `CPUDEC_OP_TXS: begin
                s_d.ctl.op = OP_TRANSFER;
                s_d.ctl.src = SEL_X;
                s_d.ctl.dst = SEL_STACK; // [RL21]
                s_d.ctl.write_result = 1'b1;
            end
            `CPUDEC_OP_PHX, `CPUDEC_OP_PHY, `CPUDEC_OP_PHA, `CPUDEC_OP_PHP: begin
                s_d.ctl.op = OP_PUSH; // [RL17]
                s_d.ctl.dst = SEL_MEMORY;
                s_d.ctl.write_result = 1'b1;
                case (opcode_i)
                    `CPUDEC_OP_PHX: s_d.ctl.src = SEL_X;
                    `CPUDEC_OP_PHY: s_d.ctl.src = SEL_Y;
                    `CPUDEC_OP_PHA: s_d.ctl.src = SEL_ACC;
                    default: s_d.ctl.src = SEL_STATUS;
                endcase
            end
            `CPUDEC_OP_PLX, `CPUDEC_OP_PLY, `CPUDEC_OP_PLA, `CPUDEC_OP_PLP: begin
                s_d.ctl.op = OP_PULL; // [RL17]
                s_d.ctl.src = SEL_MEMORY;
                s_d.ctl.write_result = 1'b1;
                s_d.ctl.update_flags = (opcode_i != `CPUDEC_OP_PLP);
                case (opcode_i)
                    `CPUDEC_OP_PLX: s_d.ctl.dst = SEL_X;
                    `CPUDEC_OP_PLY: s_d.ctl.dst = SEL_Y;
                    `CPUDEC_OP_PLA: s_d.ctl.dst = SEL_ACC;
                    default: s_d.ctl.dst = SEL_STATUS;
                endcase
            end
            `CPUDEC_OP_TSB_ZP, `CPUDEC_OP_TSB_A: begin
                s_d.ctl.op = OP_TEST_SET; // [RL18]
                s_d.ctl.src = SEL_ACC;
                s_d.ctl.dst = SEL_MEMORY;
                s_d.ctl.write_result = 1'b1;
                s_d.ctl.update_flags = 1'b1;
            end
            `CPUDEC_OP_TRB_ZP, `CPUDEC_OP_TRB_A: begin
                s_d.ctl.op = OP_TEST_RESET; // [RL19]
                s_d.ctl.src = SEL_ACC;
                s_d.ctl.dst = SEL_MEMORY;
                s_d.ctl.write_result = 1'b1;
                s_d.ctl.update_flags = 1'b1;
            end
            `CPUDEC_OP_STZ_ZP, `CPUDEC_OP_STZ_ZX, `CPUDEC_OP_STZ_A, `CPUDEC_OP_STZ_AX: begin
                s_d.ctl.op = OP_STORE_ZERO; // [RL20]
                s_d.ctl.dst = SEL_MEMORY;
                s_d.ctl.write_result = 1'b1;
            end
            default: begin
                if (col == `CPUDEC_COL_BITMEM) begin
                    s_d.ctl.op = opcode_i[`CPUDEC_SETSEL] ? OP_BIT_SET : OP_BIT_RESET; // [RL23]
                    s_d.ctl.bit_index = opcode_i[`CPUDEC_BIT_HI:`CPUDEC_BIT_LO]; // [RL23]
                    s_d.ctl.bit_value = opcode_i[`CPUDEC_SETSEL];
                    s_d.ctl.dst = SEL_MEMORY;
                    s_d.ctl.write_result = 1'b1;
                end else if (col == `CPUDEC_COL_BITBR) begin
                    s_d.ctl.op = OP_BRANCH_BIT; // [RL23]
                    s_d.ctl.bit_index = opcode_i[`CPUDEC_BIT_HI:`CPUDEC_BIT_LO]; // [RL23]
                    s_d.ctl.bit_value = opcode_i[`CPUDEC_SETSEL];
                    s_d.ctl.src = SEL_MEMORY;
                end else if (is_alu_col(col) && (row[0] || col != `CPUDEC_COL_ALU2)
                             && row[3:1] == `CPUDEC_ROW_ADC) begin
                    s_d.ctl.op = OP_ADD_CARRY; // [RL9]
                    s_d.ctl.src = SEL_MEMORY;
                    s_d.ctl.dst = SEL_ACC;
                    s_d.ctl.use_carry = 1'b1;
                    s_d.ctl.write_result = 1'b1;
                    s_d.ctl.update_flags = 1'b1;
                end else if (is_alu_col(col) && (row[0] || col != `CPUDEC_COL_ALU2)
                             && row[3:1] == `CPUDEC_ROW_SBC) begin
                    s_d.ctl.op = OP_SUBTRACT_BORROW; // [RL10]
                    s_d.ctl.src = SEL_MEMORY;
                    s_d.ctl.dst = SEL_ACC;
                    s_d.ctl.use_carry = 1'b1;
                    s_d.ctl.carry_inverted = 1'b1; // [RL10]
                    s_d.ctl.write_result = 1'b1;
                    s_d.ctl.update_flags = 1'b1;
                end else if (is_alu_col(col) && (row[0] || col != `CPUDEC_COL_ALU2)
                             && row[3:1] == `CPUDEC_ROW_CMP) begin
                    s_d.ctl.op = OP_COMPARE; // [RL15]
                    s_d.ctl.src = SEL_MEMORY;
                    s_d.ctl.dst = SEL_ACC;
                    s_d.ctl.update_flags = 1'b1;
                end else if ((row == `CPUDEC_ROW_CPX || row == `CPUDEC_ROW_CPY) &&
                             (col == `CPUDEC_COL_CPI0 || col == `CPUDEC_COL_CPI4 ||
                              col == `CPUDEC_COL_CPIC)) begin
                    s_d.ctl.op = OP_COMPARE; // [RL16]
                    s_d.ctl.src = SEL_MEMORY;
                    s_d.ctl.dst = (row == `CPUDEC_ROW_CPX) ? SEL_X : SEL_Y;
                    s_d.ctl.update_flags = 1'b1;
                end else if (!row[3] && (acc_form || col == `CPUDEC_COL_SH6 || col == `CPUDEC_COL_SHE)) begin
                    case (row[3:1])
                        `CPUDEC_ROW_ASL: s_d.ctl.op = OP_SHIFT_LEFT; // [RL11]
                        `CPUDEC_ROW_ROL: s_d.ctl.op = OP_ROTATE_LEFT; // [RL13]
                        `CPUDEC_ROW_LSR: s_d.ctl.op = OP_SHIFT_RIGHT; // [RL12]
                        default: s_d.ctl.op = OP_ROTATE_RIGHT; // [RL14]
                    endcase
                    s_d.ctl.src = acc_form ? SEL_ACC : SEL_MEMORY;
                    s_d.ctl.dst = acc_form ? SEL_ACC : SEL_MEMORY; // [RL11] [RL12]
                    s_d.ctl.use_carry = row[1]; // [RL13] [RL14]
                    s_d.ctl.write_result = 1'b1;
                    s_d.ctl.update_flags = 1'b1;
                end else begin
                    s_d.ctl.op = OP_OTHER;
                end
            end
        endcase
        if (!opcode_valid_i) begin
            s_d.ctl = ctl_blank(); // [RL24]
        end
    end

    // ======================================================
    // state register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ctl_valid_o = s_q.valid;
    assign ctl_o = s_q.ctl;

endmodule

// [tb/cpudec_fetch_model.sv]
/*
  fetch side model: presents one opcode and the flags per call.
  assumes the bench calls put once per cycle from one thread.
*/
module cpudec_fetch_model (
    // clock
    input wire logic mclk_i,
    // toward the decoder
    output logic opcode_valid_o,
    output logic [7:0] opcode_o,
    output logic [7:0] status_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        opcode_valid_o = 1'b0;
        opcode_o = 8'h00;
        status_o = 8'h00;
    end
    // ==========================================================
    // drive after the edge; an idle byte is the inverse of the last
    task automatic put(logic [7:0] o, logic [7:0] s, logic v);
        @(posedge mclk_i);
        opcode_valid_o <= v;
        opcode_o <= v ? o : ~opcode_o;
        status_o <= s;
    endtask
endmodule

// [tb/cpudec_decoder_chk.sv]
/*
  port checker of the instruction decoder, bound to it below.
  assumes one clock mclk_i and the asynchronous reset rst_i.
*/
module cpudec_chk
    import cpudec_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // fetch side
    input wire logic opcode_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] status_i,
    // datapath side
    input wire logic ctl_valid_o,
    input wire cpudec_ctl_t ctl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // an opcode counts only when presented outside reset
    wire logic live = opcode_valid_i && !rst_i;
    // ==========================================================
    // branches
    property br_p(logic [7:0] code, int fb);
        live && opcode_i == code |=>
            ctl_o.op == OP_BRANCH && ctl_o.branch_taken == ($past(status_i[fb]) == code[5]);
    endproperty
    carry_clear_a: assert property (br_p(8'h90, 0))
        else $error("carry clear branch wrong");
    carry_set_a: assert property (br_p(8'hb0, 0))
        else $error("carry set branch wrong");
    zero_set_a: assert property (br_p(8'hf0, 1))
        else $error("zero set branch wrong");
    zero_clear_a: assert property (br_p(8'hd0, 1))
        else $error("zero clear branch wrong");
    neg_set_a: assert property (br_p(8'h30, 7))
        else $error("negative set branch wrong");
    neg_clear_a: assert property (br_p(8'h10, 7))
        else $error("negative clear branch wrong");
    ovf_clear_a: assert property (br_p(8'h50, 6))
        else $error("overflow clear branch wrong");
    ovf_set_a: assert property (br_p(8'h70, 6))
        else $error("overflow set branch wrong");
    always_taken_a: assert property (live && opcode_i == 8'h80 |=> ctl_o.branch_taken)
        else $error("always branch not taken");
    // ==========================================================
    // operand classes
    bit_index_a: assert property (live && opcode_i[3:0] == 4'h7 |=>
        ctl_o.bit_index == $past(opcode_i[6:4]) && (ctl_o.op == OP_BIT_SET) == $past(opcode_i[7]))
        else $error("bit index or set select wrong");
    unused_quiet_a: assert property (live && opcode_i[3:0] == 4'h3 |=>
        !ctl_o.write_result && !ctl_o.update_flags)
        else $error("unassigned opcode writes");
    sub_inv_a: assert property (live && opcode_i[7:5] == 3'h7 && opcode_i[1:0] == 2'h1 |=>
        ctl_o.op == OP_SUBTRACT_BORROW && ctl_o.carry_inverted)
        else $error("subtract borrow not inverted");
    cmp_keep_a: assert property (live && opcode_i[7:5] == 3'h6 && opcode_i[1:0] == 2'h1 |=>
        ctl_o.op == OP_COMPARE && !ctl_o.write_result && ctl_o.update_flags)
        else $error("compare writes or skips flags");
    cover property (opcode_valid_i && opcode_i[4:0] == 5'h10 ##1 ctl_o.branch_taken);
    cover property (opcode_valid_i && opcode_i[3:0] == 4'h7 ##1 opcode_valid_i && opcode_i[3:0] == 4'hf);
    cover property (!opcode_valid_i ##1 opcode_valid_i ##1 ctl_valid_o);
endmodule

bind cpudec_decoder cpudec_chk u_chk (
    .mclk_i, .rst_i, .opcode_valid_i, .opcode_i, .status_i, .ctl_valid_o, .ctl_o
);

// [tb/tb_cpu8_instruction_decoder.sv]
/*
  testbench of the decoder: opcode sweep, branch corners, random mix, mid-run reset.
  assumes the fetch model and the bound checker are compiled before it.
*/
module tb_cpu8_instruction_decoder
    import cpudec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // wiring
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic opcode_valid_i;
    logic [7:0] opcode_i;
    logic [7:0] status_i;
    logic ctl_valid_o;
    cpudec_ctl_t ctl_o;
    int errors = 0;
    int cmp_count = 0;
    logic [7:0] pv_o, pv_s;
    logic pv_v = 1'b0;
    logic [7:0] brs [9] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h80, 8'h90, 8'hb0, 8'hd0, 8'hf0};
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    cpudec_fetch_model u_fetch (.mclk_i, .opcode_valid_o(opcode_valid_i), .opcode_o(opcode_i), .status_o(status_i));
    cpudec_decoder u_dut (.mclk_i, .rst_i, .opcode_valid_i, .opcode_i, .status_i, .ctl_valid_o, .ctl_o);
    // ==========================================================
    // expectations
    function automatic cpudec_op_t exp_op(logic [7:0] o);
        case (o)
            8'h10, 8'h30, 8'h50, 8'h70, 8'h80, 8'h90, 8'hb0, 8'hd0, 8'hf0: return OP_BRANCH;
            8'h00: return OP_BREAK;
            8'hea: return OP_NONE;
            8'hcb: return OP_WAIT;
            8'hdb: return OP_STOP;
            8'h9a: return OP_TRANSFER;
            8'h08, 8'h48, 8'h5a, 8'hda: return OP_PUSH;
            8'h28, 8'h68, 8'h7a, 8'hfa: return OP_PULL;
            8'h04, 8'h0c: return OP_TEST_SET;
            8'h14, 8'h1c: return OP_TEST_RESET;
            8'h64, 8'h74, 8'h9c, 8'h9e: return OP_STORE_ZERO;
            8'hc0, 8'hc4, 8'hcc, 8'he0, 8'he4, 8'hec, 8'hd2: return OP_COMPARE;
            8'h72: return OP_ADD_CARRY;
            8'hf2: return OP_SUBTRACT_BORROW;
            8'h0a: return OP_SHIFT_LEFT;
            8'h2a: return OP_ROTATE_LEFT;
            8'h4a: return OP_SHIFT_RIGHT;
            8'h6a: return OP_ROTATE_RIGHT;
            default: ;
        endcase
        if (o[3:0] == 4'h7) return o[7] ? OP_BIT_SET : OP_BIT_RESET;
        if (o[3:0] == 4'hf) return OP_BRANCH_BIT;
        if (o[1:0] == 2'h1 && o[7:5] == 3'h3) return OP_ADD_CARRY;
        if (o[1:0] == 2'h1 && o[7:5] == 3'h7) return OP_SUBTRACT_BORROW;
        if (o[1:0] == 2'h1 && o[7:5] == 3'h6) return OP_COMPARE;
        if (o[2:0] == 3'h6 && !o[7]) begin
            case (o[6:5])
                2'h0: return OP_SHIFT_LEFT;
                2'h1: return OP_ROTATE_LEFT;
                2'h2: return OP_SHIFT_RIGHT;
                default: return OP_ROTATE_RIGHT;
            endcase
        end
        return OP_OTHER;
    endfunction
    function automatic logic exp_taken(logic [7:0] o, logic [7:0] s);
        logic [2:0] fb;
        fb = o[7:6] == 2'h0 ? 3'h7 : o[7:6] == 2'h1 ? 3'h6 : {2'h0, o[7:6] == 2'h3};
        return o == 8'h80 || s[fb] == o[5];
    endfunction
    // ==========================================================
    // comparison and checking
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic judge(logic [7:0] o, logic [7:0] s, logic v, logic r);
        cpudec_op_t e;
        e = exp_op(o);
        if (r) chk("reset ctl", ctl_o, 32'h0);
        chk("valid", ctl_valid_o, v);
        if (!v) begin
            chk("blank op", ctl_o.op, OP_NONE);
            return;
        end
        chk("op", ctl_o.op, e);
        if (e == OP_BRANCH) chk("taken", ctl_o.branch_taken, exp_taken(o, s));
        if (e inside {OP_ADD_CARRY, OP_SUBTRACT_BORROW}) chk("acc dst", ctl_o.dst, SEL_ACC);
        if (e inside {OP_ADD_CARRY, OP_SUBTRACT_BORROW}) chk("carry use", ctl_o.use_carry, 1'b1);
        if (e inside {OP_ADD_CARRY, OP_SUBTRACT_BORROW}) chk("inv borrow", ctl_o.carry_inverted, o[7]);
        if (e inside {OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT}) begin
            chk("shift wr", ctl_o.write_result, 1'b1);
            chk("place", {ctl_o.src, ctl_o.dst}, o[2] ? {SEL_MEMORY, SEL_MEMORY} : {SEL_ACC, SEL_ACC});
            chk("carry in", ctl_o.use_carry, e inside {OP_ROTATE_LEFT, OP_ROTATE_RIGHT});
        end
        if (e == OP_COMPARE) chk("cmp keep", {ctl_o.write_result, ctl_o.update_flags}, 2'h1);
        if (o inside {8'h5a, 8'hda}) chk("push src", ctl_o.src, o[7] ? SEL_X : SEL_Y);
        if (o inside {8'h7a, 8'hfa}) chk("pull dst", ctl_o.dst, o[7] ? SEL_X : SEL_Y);
        if (e inside {OP_TEST_SET, OP_TEST_RESET, OP_STORE_ZERO}) chk("mem wr", ctl_o.write_result, 1'b1);
        if (e == OP_TRANSFER) chk("x to sp", {ctl_o.src, ctl_o.dst}, {SEL_X, SEL_STACK});
        if (o[3:0] inside {4'h7, 4'hf}) chk("bit idx", ctl_o.bit_index, o[6:4]);
        if (o[3:0] == 4'h3) chk("no write", {ctl_o.write_result, ctl_o.update_flags}, 2'h0);
    endtask
    // one opcode per cycle; the answer to the previous one is judged mid-cycle
    task automatic step(logic [7:0] o, logic [7:0] s, logic v, logic r);
        u_fetch.put(o, s, v);
        rst_i <= r;
        @(negedge mclk_i);
        if (r) pv_v = 1'b0;
        judge(pv_o, pv_s, pv_v, r);
        pv_o = o;
        pv_s = s;
        pv_v = v && !r;
    endtask
    task automatic close_out();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'h9aad));
        repeat (20) step(8'h00, 8'h00, 1'b0, 1'b1);
        for (int i = 0; i < 256; i++) step(i[7:0], 8'($urandom), 1'b1, 1'b0);
        foreach (brs[k]) begin
            step(brs[k], 8'h00, 1'b1, 1'b0);
            step(brs[k], 8'hff, 1'b1, 1'b0);
        end
        repeat (400) step(8'($urandom), 8'($urandom), ($urandom % 4) != 0, 1'b0);
        repeat (3) step(8'h90, 8'h00, 1'b1, 1'b1);
        for (int i = 0; i < 256; i += 17) step(i[7:0], 8'($urandom), 1'b1, 1'b0);
        step(8'hea, 8'h00, 1'b0, 1'b0);
        close_out();
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        errors++;
        $display("[FAIL] run length expected end seen hang");
        close_out();
    end
endmodule
